// file: shared/updown_timer_pkg.sv
// constants, register map and field layouts of the up/down timer with compare/capture
package updown_timer_pkg;

    localparam int unsigned NUM_CC     = 2;
    localparam int unsigned CNT_W      = 16;
    localparam int unsigned ADDR_W     = 6;
    localparam int unsigned DATA_W     = 32;

    // byte offsets, one aligned word each
    localparam logic [ADDR_W-1:0] OFS_CTRL   = 6'h00;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h04;
    localparam logic [ADDR_W-1:0] OFS_MAX    = 6'h08;
    localparam logic [ADDR_W-1:0] OFS_COUNT  = 6'h0c;
    localparam logic [ADDR_W-1:0] OFS_FLAGS  = 6'h10;
    localparam logic [ADDR_W-1:0] OFS_IRQEN  = 6'h14;
    localparam logic [ADDR_W-1:0] OFS_CCCTL0 = 6'h18;
    localparam logic [ADDR_W-1:0] OFS_CCCTL1 = 6'h1c;
    localparam logic [ADDR_W-1:0] OFS_CCDAT0 = 6'h20;
    localparam logic [ADDR_W-1:0] OFS_CCDAT1 = 6'h24;

    // counter_control_reg fields
    localparam int unsigned CTL_MODEN  = 0;
    localparam int unsigned CTL_PRESET = 1;
    localparam int unsigned CTL_RUN    = 2;
    localparam int unsigned CTL_SINGLE = 3;
    localparam int unsigned CTL_DIR_LO = 4;
    // counter_status_reg fields
    localparam int unsigned STS_ACTIVE = 0;
    localparam int unsigned STS_UP     = 1;
    // flag / enable layout
    localparam int unsigned FLG_CC     = 0;   // bits 1:0
    localparam int unsigned FLG_TOP    = 2;
    localparam int unsigned FLG_BOTTOM = 3;
    localparam int unsigned FLG_OVR    = 4;   // bits 5:4
    localparam int unsigned FLG_W      = 6;

    localparam logic [CNT_W-1:0] CNT_ZERO  = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE   = 16'h0001;
    localparam logic [CNT_W-1:0] MAX_RESET = 16'hffff;

    typedef enum logic [1:0] {
        DIR_UP     = 2'b00,
        DIR_DOWN   = 2'b01,
        DIR_UPDOWN = 2'b10,
        DIR_RSVD   = 2'b11
    } direction_mode_e;

    typedef enum logic [2:0] {
        BUF_ON_WRITE = 3'b000,
        BUF_AT_ZERO  = 3'b001,
        BUF_AT_MAX   = 3'b010,
        BUF_AT_EITHER= 3'b011,
        BUF_WHEN_IDLE= 3'b100
    } buffer_load_timing_e;

    typedef enum logic [1:0] {
        EDGE_NONE    = 2'b00,
        EDGE_RISE    = 2'b01,
        EDGE_FALL    = 2'b10,
        EDGE_BOTH    = 2'b11
    } trigger_edge_e;

    // trigger sources: the line, tied low, software low, software high
    localparam logic [1:0] SRC_LINE    = 2'h0;
    localparam logic [1:0] SRC_SW_HIGH = 2'h3;

    // circuit_control_reg layout (bits 7:0)
    typedef struct packed {
        logic [1:0] trigger_edge_select;   // bits 7:6
        logic [1:0] trigger_source_select; // bits 5:4
        logic [2:0] buffer_load_timing;    // bits 3:1
        logic       circuit_mode_select;   // bit 0: 0 compare, 1 capture
    } circuit_ctrl_s;
    localparam int unsigned CCTL_W = 8;

endpackage

// file: verilog/updown_timer_compare_capture.sv
// 16-bit up/down counter with two compare/capture circuits behind an avalon-mm slave
//
// How it works
// R1: status bit counting_active reads 1 while counting, 0 while idle.
// R2: status direction bit reads 1 when counting up, 0 when counting down.
// R3: repeat up counts to max, wraps to zero, runs until run cleared.
// R4: one-shot up wraps to zero after max and then halts.
// R5: up count: larger max continues; max below count clears to zero.
// R6: repeat down counts to zero, reloads max on underflow, continues.
// R7: in down count a changed max is used only at next reload.
// R8: one-shot down reloads max on underflow and then stops.
// R9: repeat up/down alternates zero to max and max back to zero.
// R10: max changed during descent: finish to zero, then climb to new max.
// R11: one-shot up/down stops on reaching zero while descending.
// R12: per-circuit mode bit: 0 comparator, 1 capture.
// R13: comparator match with buffered value pulses match and sets circuit flag.
// R14: top flag set on reaching max, bottom flag on reaching zero.
// R15: shared line is timer output in compare, trigger input in capture.
// R16: compare buffer loads from data register at time chosen by 3-bit code.
// R17: capture uses 2-bit trigger source and 2-bit edge select fields.
// R18: selected edge while counting captures count and sets circuit flag.
// R19: capture while circuit flag still set raises overrun flag.
// R20: compare interval cc+1 up, max-cc+1 down; cycle max+1 clocks in up or down count, 2*max in up/down.
// R21: one-shot stop clears run control automatically.
// R22: flags clear by writing 1; irq only for set and enabled flags.
// R23: direction 0 up, 1 down, 2 up/down, 3 reserved; single-pass bit.
// R24: buffer code 0 loads on write, codes 1-3 at zero/max events or while idle, code 4 only while idle.
// R25: status, flags and count change only on clock edges.
`timescale 1ns/1ps
module updown_timer_compare_capture
    import updown_timer_pkg::*;
(
    input  wire logic                 mclk,
    input  wire logic                 rstn,
    input  wire logic [ADDR_W-1:0]    avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [DATA_W-1:0]    avs_writedata,
    input  wire logic [3:0]           avs_byteenable,
    output logic      [DATA_W-1:0]    avs_readdata,
    output logic                      avs_waitrequest,
    input  wire logic [NUM_CC-1:0]    cc_line_in,
    output logic      [NUM_CC-1:0]    cc_line_out,
    output logic      [NUM_CC-1:0]    cc_line_oe,
    output logic      [NUM_CC-1:0]    match_q,
    output logic                      irq_q
);

    // ---------------- bus slave ----------------
    logic                    wait_q;
    logic                    wr_en;
    logic [15:0]             wmask;
    logic [15:0]             wdata16;
    logic [DATA_W-1:0]       rdata_d;

    // one wait cycle per access: the access completes at the edge where wait is low
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wait_q <= 1'b1;
        end else if ((avs_read || avs_write) && wait_q) begin
            wait_q <= 1'b0;
        end else begin
            wait_q <= 1'b1;
        end
    end
    assign avs_waitrequest = wait_q;
    assign wr_en   = avs_write && !wait_q;
    assign wmask   = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign wdata16 = avs_writedata[15:0] & wmask;

    // ---------------- control registers ----------------
    logic                    moden_q;
    logic                    run_q;
    logic                    single_q;
    direction_mode_e         dir_q;
    logic [CNT_W-1:0]        max_q;
    logic [FLG_W-1:0]        irqen_q;
    circuit_ctrl_s           cctl_q [NUM_CC];
    logic                    stop_evt;
    logic                    preset_req;
    logic                    run_wr;

    assign run_wr     = wr_en && (avs_address == OFS_CTRL) && avs_byteenable[0];
    assign preset_req = run_wr && avs_writedata[CTL_PRESET]
                        && (avs_writedata[CTL_MODEN] || moden_q);

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            moden_q  <= 1'b0;
            single_q <= 1'b0;
            dir_q    <= DIR_UP;
        end else if (run_wr) begin
            moden_q  <= avs_writedata[CTL_MODEN];
            single_q <= avs_writedata[CTL_SINGLE];                       // R23
            dir_q    <= direction_mode_e'(avs_writedata[CTL_DIR_LO +: 2]); // R23
        end
    end

    // a software write wins over the automatic stop in the same cycle
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            run_q <= 1'b0;
        end else if (run_wr) begin
            run_q <= avs_writedata[CTL_RUN] && (avs_writedata[CTL_MODEN] || moden_q);
        end else if (stop_evt) begin
            run_q <= 1'b0;                                               // R21
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            max_q <= MAX_RESET;
        end else if (wr_en && avs_address == OFS_MAX) begin
            max_q <= (max_q & ~wmask) | wdata16;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            irqen_q <= '0;
        end else if (wr_en && avs_address == OFS_IRQEN && avs_byteenable[0]) begin
            irqen_q <= avs_writedata[FLG_W-1:0];
        end
    end

    // ---------------- counter ----------------
    logic [CNT_W-1:0]        cnt_q;
    logic [CNT_W-1:0]        cnt_d;
    logic                    up_q;
    logic                    up_d;
    logic                    counting;
    logic                    top_evt;
    logic                    bottom_evt;

    assign counting = run_q && moden_q && (dir_q != DIR_RSVD);

    always_comb begin
        cnt_d    = cnt_q;
        up_d     = up_q;
        stop_evt = 1'b0;
        if (preset_req) begin
            cnt_d = (avs_writedata[CTL_DIR_LO +: 2] == DIR_DOWN) ? max_q : CNT_ZERO;
            up_d  = (avs_writedata[CTL_DIR_LO +: 2] != DIR_DOWN);
        end else if (counting) begin
            unique case (dir_q)
                DIR_UP: begin
                    up_d = 1'b1;
                    if (cnt_q > max_q) begin
                        cnt_d = CNT_ZERO;                                // R5
                    end else if (cnt_q == max_q) begin
                        cnt_d    = CNT_ZERO;                             // R3
                        stop_evt = single_q;                             // R4
                    end else begin
                        cnt_d = cnt_q + CNT_ONE;                         // R3
                    end
                end
                DIR_DOWN: begin
                    up_d = 1'b0;
                    if (cnt_q == CNT_ZERO) begin
                        cnt_d    = max_q;                                // R6 R7
                        stop_evt = single_q;                             // R8
                    end else begin
                        cnt_d = cnt_q - CNT_ONE;                         // R6
                    end
                end
                DIR_UPDOWN: begin
                    if (up_q) begin
                        if (cnt_q > max_q) begin
                            cnt_d = CNT_ZERO;                            // R5
                        end else if (cnt_q == max_q) begin
                            up_d     = 1'b0;                             // R9
                            cnt_d    = (max_q == CNT_ZERO) ? CNT_ZERO : cnt_q - CNT_ONE;
                            stop_evt = single_q && (max_q == CNT_ZERO);  // R11
                        end else begin
                            cnt_d = cnt_q + CNT_ONE;                     // R9
                        end
                    end else begin
                        if (cnt_q == CNT_ZERO) begin
                            up_d  = 1'b1;                                // R10
                            cnt_d = (max_q == CNT_ZERO) ? CNT_ZERO : CNT_ONE;
                        end else begin
                            cnt_d    = cnt_q - CNT_ONE;                  // R10
                            stop_evt = single_q && (cnt_q == CNT_ONE);   // R11
                        end
                    end
                end
                default: begin
                    cnt_d = cnt_q;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= CNT_ZERO;
            up_q  <= 1'b1;
        end else begin
            cnt_q <= cnt_d;                                              // R25
            up_q  <= up_d;
        end
    end

    // events mark the count arriving at max or zero; max+1 clocks apart per pass in up or down count
    assign top_evt    = counting && (cnt_d == max_q) && (cnt_q != cnt_d);   // R14 R20
    assign bottom_evt = counting && (cnt_d == CNT_ZERO) && (cnt_q != cnt_d); // R14 R20

    // ---------------- flags ----------------
    logic                    flg_wr;
    logic [FLG_W-1:0]        clr;
    logic [NUM_CC-1:0]       cc_flag_q;
    logic [NUM_CC-1:0]       ovr_flag_q;
    logic                    top_flag_q;
    logic                    bottom_flag_q;
    logic [FLG_W-1:0]        flags;

    assign flg_wr = wr_en && (avs_address == OFS_FLAGS) && avs_byteenable[0];
    assign clr    = flg_wr ? avs_writedata[FLG_W-1:0] : '0;             // R22
    assign flags  = {ovr_flag_q, bottom_flag_q, top_flag_q, cc_flag_q};

    // set wins over a clear written in the same cycle
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            top_flag_q    <= 1'b0;
            bottom_flag_q <= 1'b0;
        end else begin
            top_flag_q    <= (top_flag_q & ~clr[FLG_TOP]) | top_evt;          // R14 R22
            bottom_flag_q <= (bottom_flag_q & ~clr[FLG_BOTTOM]) | bottom_evt; // R14 R22
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(flags & irqen_q);                                 // R22
        end
    end

    // ---------------- compare / capture circuits ----------------
    logic [CNT_W-1:0]        ccdat_q [NUM_CC];
    logic [CNT_W-1:0]        cbuf_q  [NUM_CC];

    for (genvar m = 0; m < NUM_CC; m++) begin : g_cc
        logic             cctl_wr;
        logic             dat_wr;
        logic             is_cap;
        logic             trig;
        logic             trig_prev_q;
        logic             edge_hit;
        logic             cap_evt;
        logic             cmp_evt;
        logic             buf_load;
        buffer_load_timing_e bmode;

        assign cctl_wr = wr_en && avs_byteenable[0]
                         && (avs_address == (OFS_CCCTL0 + ADDR_W'(4 * m)));
        assign dat_wr  = wr_en && (avs_address == (OFS_CCDAT0 + ADDR_W'(4 * m)));
        assign is_cap  = cctl_q[m].circuit_mode_select;                  // R12
        assign bmode   = buffer_load_timing_e'(cctl_q[m].buffer_load_timing);

        always_ff @(posedge mclk or negedge rstn) begin
            if (!rstn) begin
                cctl_q[m] <= '0;
            end else if (cctl_wr) begin
                cctl_q[m] <= circuit_ctrl_s'(avs_writedata[CCTL_W-1:0]); // R12 R16 R17
            end
        end

        // trigger source: the line, tied low, or a software-driven level
        always_comb begin
            unique case (cctl_q[m].trigger_source_select)
                SRC_LINE:    trig = cc_line_in[m];                       // R15 R17
                SRC_SW_HIGH: trig = 1'b1;
                default:     trig = 1'b0;
            endcase
        end

        always_ff @(posedge mclk or negedge rstn) begin
            if (!rstn) begin
                trig_prev_q <= 1'b0;
            end else begin
                trig_prev_q <= trig;
            end
        end

        always_comb begin
            unique case (trigger_edge_e'(cctl_q[m].trigger_edge_select))
                EDGE_RISE: edge_hit = trig && !trig_prev_q;              // R17
                EDGE_FALL: edge_hit = !trig && trig_prev_q;
                EDGE_BOTH: edge_hit = trig ^ trig_prev_q;
                EDGE_NONE: edge_hit = 1'b0;
            endcase
        end

        assign cap_evt = is_cap && counting && edge_hit;                 // R18
        // the buffered value is compared, so with a deferred load code a mid-period write cannot cut a cycle short
        assign cmp_evt = !is_cap && counting && (cnt_q == cbuf_q[m]);   // R13 R20

        // codes 1-3 defer the load to count boundaries and code 4 to idle time (mid-count
        // writes would otherwise distort a pwm duty cycle)
        always_comb begin
            unique case (bmode)
                BUF_ON_WRITE:  buf_load = 1'b1;                          // R24
                BUF_AT_ZERO:   buf_load = bottom_evt || !counting;       // R24
                BUF_AT_MAX:    buf_load = top_evt || !counting;          // R24
                BUF_AT_EITHER: buf_load = bottom_evt || top_evt || !counting;
                BUF_WHEN_IDLE: buf_load = !counting;
                default:       buf_load = 1'b0;
            endcase
        end

        always_ff @(posedge mclk or negedge rstn) begin
            if (!rstn) begin
                cbuf_q[m] <= CNT_ZERO;
            end else if (buf_load) begin
                cbuf_q[m] <= ccdat_q[m];                                 // R16
            end
        end

        // a capture wins over a software write in the same cycle
        always_ff @(posedge mclk or negedge rstn) begin
            if (!rstn) begin
                ccdat_q[m] <= CNT_ZERO;
            end else if (cap_evt) begin
                ccdat_q[m] <= cnt_q;                                     // R18
            end else if (dat_wr) begin
                ccdat_q[m] <= (ccdat_q[m] & ~wmask) | wdata16;
            end
        end

        always_ff @(posedge mclk or negedge rstn) begin
            if (!rstn) begin
                cc_flag_q[m]  <= 1'b0;
                ovr_flag_q[m] <= 1'b0;
            end else begin
                cc_flag_q[m]  <= (cc_flag_q[m] & ~clr[FLG_CC + m]) | cmp_evt | cap_evt; // R13 R18
                ovr_flag_q[m] <= (ovr_flag_q[m] & ~clr[FLG_OVR + m])
                                 | (cap_evt && cc_flag_q[m]);                          // R19
            end
        end

        always_ff @(posedge mclk or negedge rstn) begin
            if (!rstn) begin
                match_q[m]     <= 1'b0;
                cc_line_out[m] <= 1'b0;
                cc_line_oe[m]  <= 1'b0;
            end else begin
                match_q[m]     <= cmp_evt;                               // R13
                cc_line_oe[m]  <= !is_cap;                               // R15
                if (is_cap) begin
                    cc_line_out[m] <= 1'b0;
                end else if (cmp_evt) begin
                    cc_line_out[m] <= !cc_line_out[m];                   // R15
                end
            end
        end
    end

    // ---------------- read mux ----------------
    always_comb begin
        rdata_d = '0;
        unique case (avs_address)
            OFS_CTRL: begin
                rdata_d[CTL_MODEN]         = moden_q;
                rdata_d[CTL_RUN]           = run_q;
                rdata_d[CTL_SINGLE]        = single_q;
                rdata_d[CTL_DIR_LO +: 2]   = dir_q;
            end
            OFS_STATUS: begin
                rdata_d[STS_ACTIVE] = counting;                          // R1
                rdata_d[STS_UP]     = up_q;                              // R2
            end
            OFS_MAX:    rdata_d[CNT_W-1:0]  = max_q;
            OFS_COUNT:  rdata_d[CNT_W-1:0]  = cnt_q;
            OFS_FLAGS:  rdata_d[FLG_W-1:0]  = flags;
            OFS_IRQEN:  rdata_d[FLG_W-1:0]  = irqen_q;
            OFS_CCCTL0: rdata_d[CCTL_W-1:0] = cctl_q[0];
            OFS_CCCTL1: rdata_d[CCTL_W-1:0] = cctl_q[1];
            OFS_CCDAT0: rdata_d[CNT_W-1:0]  = ccdat_q[0];
            OFS_CCDAT1: rdata_d[CNT_W-1:0]  = ccdat_q[1];
            default:    rdata_d = '0;
        endcase
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            avs_readdata <= '0;
        end else if (avs_read && wait_q) begin
            avs_readdata <= rdata_d;
        end
    end

endmodule // updown_timer_compare_capture

// file: testbench/updown_timer_checker.sv
// concurrent checks on bus handshake, timer output lines and match pulses
`timescale 1ns/1ps
module updown_timer_checker
    import updown_timer_pkg::*;
(
    input wire logic              mclk,
    input wire logic              rstn,
    input wire logic              avs_read,
    input wire logic              avs_write,
    input wire logic [DATA_W-1:0] avs_readdata,
    input wire logic              avs_waitrequest,
    input wire logic [NUM_CC-1:0] cc_line_out,
    input wire logic [NUM_CC-1:0] cc_line_oe,
    input wire logic [NUM_CC-1:0] match_q
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=>
        !avs_waitrequest) else $error("request not answered in one cycle");
    a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_wait_cause: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
        else $error("waitrequest low without a request");
    a_wait_idle: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
        else $error("waitrequest low after an idle cycle");
    a_rdata_hold: assert property ($changed(avs_readdata) |-> $past(avs_read))
        else $error("read data moved without a read");
    a_line_idle: assert property ((cc_line_out & ~cc_line_oe) == '0)
        else $error("output high on a line that is not driven");
    a_match_mode: assert property ((match_q & ~cc_line_oe) == '0)
        else $error("match pulse from a circuit in capture mode");
    // while no output enable changes, the line may only move together with its own match pulse
    a_line_toggle: assert property (cc_line_oe == $past(cc_line_oe) |->
        ((cc_line_out ^ $past(cc_line_out)) & ~match_q) == '0)
        else $error("timer output moved without a match");
endmodule // updown_timer_checker

bind updown_timer_compare_capture updown_timer_checker u_chk (
    .mclk(mclk), .rstn(rstn), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cc_line_out(cc_line_out), .cc_line_oe(cc_line_oe), .match_q(match_q));

// file: testbench/updown_timer_line_model.sv
// far side of the shared compare/capture lines: trigger source and output observer
`timescale 1ns/1ps
module updown_timer_line_model
    import updown_timer_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic [NUM_CC-1:0] line_oe,
    input  wire logic [NUM_CC-1:0] line_out,
    output logic      [NUM_CC-1:0] line_level
);
    logic [NUM_CC-1:0] ext_q = '0;

    // a driven pin shows the timer output, a released one the external trigger
    assign line_level = (line_oe & line_out) | (~line_oe & ext_q);

    // held three clocks so the synchronous edge detector cannot miss it
    task automatic pulse(input int m);
        @(posedge mclk);
        ext_q[m] <= 1'b1;
        repeat (3) @(posedge mclk);
        ext_q[m] <= 1'b0;
    endtask
endmodule // updown_timer_line_model

// file: testbench/test_updown_timer_compare_capture.sv
// self-checking bench for the up/down timer with compare/capture
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
    $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module test_updown_timer_compare_capture import updown_timer_pkg::*;;
    typedef struct packed {logic wr; logic [ADDR_W-1:0] a; logic [DATA_W-1:0] v;} row_s;
    logic              mclk, rstn, avs_read, avs_write, avs_waitrequest, irq_q;
    logic [ADDR_W-1:0] avs_address;
    logic [DATA_W-1:0] avs_writedata, avs_readdata, d;
    logic [3:0]        avs_byteenable;
    logic [NUM_CC-1:0] line_in, line_out, line_oe, match_q;
    int                failures = 0;
    int                cmp_count = 0;
    row_s rows [12] = '{'{1'b0, OFS_CTRL, 32'h0}, '{1'b0, OFS_STATUS, 32'h2},
        '{1'b0, OFS_MAX, 32'hffff}, '{1'b0, OFS_COUNT, 32'h0}, '{1'b0, OFS_FLAGS, 32'h0},
        '{1'b0, OFS_IRQEN, 32'h0}, '{1'b0, OFS_CCCTL0, 32'h0}, '{1'b0, OFS_CCDAT1, 32'h0},
        '{1'b1, 6'h3c, 32'h5a5a}, '{1'b0, 6'h3c, 32'h0}, '{1'b1, OFS_IRQEN, 32'h3f},
        '{1'b0, OFS_IRQEN, 32'h3f}};

    updown_timer_compare_capture u_dut (.mclk(mclk), .rstn(rstn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .cc_line_in(line_in), .cc_line_out(line_out),
        .cc_line_oe(line_oe), .match_q(match_q), .irq_q(irq_q));
    updown_timer_line_model u_line (.mclk(mclk), .line_oe(line_oe), .line_out(line_out),
        .line_level(line_in));

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= v;
        avs_write <= 1'b1;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
        @(posedge mclk);
        avs_address <= a;
        avs_read <= 1'b1;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        v = avs_readdata;
        avs_read <= 1'b0;
    endtask
    task automatic rc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        rd(a, d);
        `CHK("reg", e, d)
    endtask
    // clocks between two successive match pulses of circuit 0
    task automatic period(input int e);
        int n, c, s;
        c = 0;
        s = 0;
        for (n = 0; n < 100 && c < 2; n++) begin
            @(negedge mclk);
            if (match_q[0] === 1'b1) begin
                c++;
                s = n - s;
            end
        end
        `CHK("period", e, s)
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    initial begin
        #100000;
        failures++;
        give_verdict();
    end
    initial begin
        rstn = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = '0;
        avs_writedata = '0;
        avs_byteenable = 4'hf;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        foreach (rows[k]) begin
            if (rows[k].wr) wr(rows[k].a, rows[k].v);
            else rc(rows[k].a, rows[k].v);
        end
        wr(OFS_CCCTL1, 32'h01);   // capture, edge none
        wr(OFS_CCDAT0, 32'h3);
        wr(OFS_MAX, 32'h9);
        wr(OFS_CTRL, 32'h5);
        rc(OFS_STATUS, 32'h3);
        period(10);
        rd(OFS_FLAGS, d);
        `CHK("flags", 32'h0d, d & 32'h3f)
        `CHK("irq", 1'b1, irq_q)
        `CHK("oe", 2'b01, line_oe)
        wr(OFS_CTRL, 32'h15);
        rc(OFS_STATUS, 32'h1);
        period(10);
        wr(OFS_CCDAT0, 32'h9);
        wr(OFS_CTRL, 32'h25);
        period(18);
        u_line.pulse(1);
        rd(OFS_FLAGS, d);
        `CHK("no_edge", 1'b0, d[1])
        wr(OFS_CCCTL1, 32'h41);
        u_line.pulse(1);
        rd(OFS_CCDAT1, d);
        `CHK("cap_val", 1'b1, d < 32'ha)
        u_line.pulse(1);
        rd(OFS_FLAGS, d);
        `CHK("cap_flags", 32'h22, d & 32'h22)
        wr(OFS_FLAGS, 32'h22);
        wr(OFS_CCCTL1, 32'hb1);   // fall edge, software-high source gives a rise
        rd(OFS_FLAGS, d);
        `CHK("rise_no_fall", 1'b0, d[1])
        wr(OFS_CCCTL1, 32'h81);   // back to the low line: a falling edge
        rd(OFS_FLAGS, d);
        `CHK("fall_cap", 1'b1, d[1])
        wr(OFS_CTRL, 32'h1);
        wr(OFS_FLAGS, 32'h3f);
        rc(OFS_FLAGS, 32'h0);
        `CHK("irq_off", 1'b0, irq_q)
        wr(OFS_CTRL, 32'h3);
        wr(OFS_CTRL, 32'hd);
        repeat (20) @(posedge mclk);
        rc(OFS_CTRL, 32'h9);
        rc(OFS_COUNT, 32'h0);
        wr(OFS_CTRL, 32'h13);
        rc(OFS_COUNT, 32'h9);
        wr(OFS_CTRL, 32'h1d);
        repeat (20) @(posedge mclk);
        rc(OFS_CTRL, 32'h19);
        rc(OFS_COUNT, 32'h9);
        wr(OFS_CTRL, 32'h2d);
        repeat (30) @(posedge mclk);
        rc(OFS_CTRL, 32'h29);
        rc(OFS_COUNT, 32'h0);
        wr(OFS_MAX, 32'hc8);
        wr(OFS_CTRL, 32'h5);
        repeat (100) @(posedge mclk);
        wr(OFS_MAX, 32'h9);
        rd(OFS_COUNT, d);
        `CHK("lowered_up", 1'b1, d < 32'ha)
        wr(OFS_MAX, 32'hc8);
        wr(OFS_CTRL, 32'h15);
        repeat (100) @(posedge mclk);
        wr(OFS_MAX, 32'h9);
        rd(OFS_COUNT, d);
        `CHK("descent", 1'b1, d > 32'h9)
        repeat (150) @(posedge mclk);
        rd(OFS_COUNT, d);
        `CHK("reload", 1'b1, d < 32'ha)
        rstn <= 1'b0;             // reset while counting
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        rc(OFS_COUNT, 32'h0);
        rc(OFS_STATUS, 32'h2);
        give_verdict();
    end
endmodule // test_updown_timer_compare_capture
